//--- rtl/infrared_uart_fifo_port.sv
// Infrared serial port: APB registers, receive and transmit queues, line framing
// How it works
// - 8 data bits, one stop, no parity.
// - Line runs at 115200 bits per second.
// - Received characters queue in 256-entry store.
// - Receive fill count in data bits 23:16.
// - Characters arriving when full are dropped.
// - Empty-queue read returns undefined character bits.
// - Data read pops head, shows decremented count.
// - Data write pushes character into transmit queue.
// - Data write leaves receive side untouched.
// - Transmit free space in control bits 23:16.
// - Writes to full transmit queue are dropped.
// - Enable bits gate receive and transmit interrupts.
// - Interrupt when count or space exceeds 31.
// - Pending flags clear once threshold no longer holds.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "ir_uart_defines.svh"
module infrared_uart_fifo_port (
  input  wire logic                 clk,     // Core clock, 125 MHz
  input  wire logic                 rst,     // Synchronous reset, active high
  input  wire ir_uart_pkg::apb_req_t apb_in, // APB request from the master
  output ir_uart_pkg::apb_rsp_t     apb_out, // APB response to the master
  input  wire logic                 ir_rx,   // Receive line from transceiver
  output logic                      ir_tx,   // Transmit line to transceiver
  output logic                      irq      // Level interrupt request
);
  import ir_uart_pkg::*;

  uart_state_t s;
  uart_state_t n;

  logic        rx_we;
  logic [8:0]  rx_wdata;
  logic [8:0]  rx_rdata;
  logic        rx_pop;
  logic        tx_we;
  logic [7:0]  tx_rdata;
  logic        tx_pop;
  logic        access;
  logic        rd_data;
  logic        wr_data;
  logic        rx_pend;
  logic        tx_pend;
  fifo_count_t tx_free;
  logic [2:0]  ev_set;
  logic [2:0]  ev_clr;

  // Counts of 256 do not fit the 8-bit fields, so they pin at all ones
  function automatic logic [7:0] sat8(input fifo_count_t v);
    return v[8] ? 8'hFF : v[7:0];
  endfunction

  // --------------------------------------------------------------------------
  // Character stores
  // --------------------------------------------------------------------------
  char_ram #(.WIDTH(9), .AW(8)) rx_store (
    .clk   (clk),
    .we    (rx_we),
    .waddr (s.rx_wr_ptr),
    .wdata (rx_wdata),
    .raddr (s.rx_rd_ptr),
    .rdata (rx_rdata)
  );

  char_ram #(.WIDTH(8), .AW(8)) tx_store (
    .clk   (clk),
    .we    (tx_we),
    .waddr (s.tx_wr_ptr),
    .wdata (apb_in.pwdata[`CHAR_MSB:0]),
    .raddr (s.tx_rd_ptr),
    .rdata (tx_rdata)
  );

  assign access  = apb_in.psel && apb_in.penable && (s.bus_phase == BUS_WAIT);
  assign rd_data = access && !apb_in.pwrite && (apb_in.paddr == `DATA_ADDR);
  assign wr_data = access && apb_in.pwrite && (apb_in.paddr == `DATA_ADDR);
  assign tx_free = `FIFO_DEPTH - s.tx_count;
  assign rx_pend = s.rx_count > `IRQ_THRESHOLD;
  assign tx_pend = tx_free > `IRQ_THRESHOLD;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    n        = s;
    rx_we    = 1'b0;
    rx_wdata = 9'h000;
    rx_pop   = 1'b0;
    tx_we    = 1'b0;
    tx_pop   = 1'b0;
    ev_set   = 3'h0;
    ev_clr   = 3'h0;

    // Receive line: two flops before anything looks at it
    n.rx_meta = ir_rx;
    n.rx_sync = s.rx_meta;

    // Receive framer, sampling at mid-bit
    case (s.rx_phase)
      RX_IDLE: begin
        if (!s.rx_sync) begin
          n.rx_phase = RX_START;
          n.rx_timer = bit_timer_t'(`HALF_BIT_CYCLES - 1);
        end
      end
      RX_START: begin
        if (s.rx_timer != 11'h000) begin
          n.rx_timer = s.rx_timer - 11'h001;
        end else if (!s.rx_sync) begin
          n.rx_phase = RX_DATA;
          n.rx_timer = bit_timer_t'(`BIT_CYCLES - 1);
          n.rx_bits  = 3'h0;
        end else begin
          n.rx_phase = RX_IDLE;                // Glitch, not a start bit
        end
      end
      RX_DATA: begin
        if (s.rx_timer != 11'h000) begin
          n.rx_timer = s.rx_timer - 11'h001;
        end else begin
          n.rx_shift = {s.rx_sync, s.rx_shift[7:1]};
          n.rx_timer = bit_timer_t'(`BIT_CYCLES - 1);
          n.rx_bits  = s.rx_bits + 3'h1;
          if (s.rx_bits == 3'h7) begin
            n.rx_phase = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (s.rx_timer != 11'h000) begin
          n.rx_timer = s.rx_timer - 11'h001;
        end else begin
          n.rx_phase = RX_IDLE;
          rx_wdata   = {~s.rx_sync, s.rx_shift};
          if (!s.rx_sync) begin
            ev_set[`EV_FRAME] = 1'b1;
          end
          if (s.rx_count == `FIFO_DEPTH) begin
            ev_set[`EV_RX_OVF] = 1'b1;
          end else begin
            rx_we       = 1'b1;
            n.rx_wr_ptr = s.rx_wr_ptr + 8'h01;
          end
        end
      end
      default: n.rx_phase = RX_IDLE;
    endcase

    // Transmit framer
    case (s.tx_phase)
      TX_IDLE: begin
        n.tx_line = 1'b1;
        if (s.tx_count != 9'h000) begin
          tx_pop      = 1'b1;
          n.tx_shift  = tx_rdata;
          n.tx_rd_ptr = s.tx_rd_ptr + 8'h01;
          n.tx_line   = 1'b0;
          n.tx_timer  = bit_timer_t'(`BIT_CYCLES - 1);
          n.tx_phase  = TX_START;
        end
      end
      TX_START: begin
        if (s.tx_timer != 11'h000) begin
          n.tx_timer = s.tx_timer - 11'h001;
        end else begin
          n.tx_line  = s.tx_shift[0];
          n.tx_bits  = 3'h0;
          n.tx_timer = bit_timer_t'(`BIT_CYCLES - 1);
          n.tx_phase = TX_DATA;
        end
      end
      TX_DATA: begin
        if (s.tx_timer != 11'h000) begin
          n.tx_timer = s.tx_timer - 11'h001;
        end else begin
          n.tx_timer = bit_timer_t'(`BIT_CYCLES - 1);
          if (s.tx_bits == 3'h7) begin
            n.tx_line  = 1'b1;
            n.tx_phase = TX_STOP;
          end else begin
            n.tx_shift = {1'b0, s.tx_shift[7:1]};
            n.tx_line  = s.tx_shift[1];
            n.tx_bits  = s.tx_bits + 3'h1;
          end
        end
      end
      TX_STOP: begin
        if (s.tx_timer != 11'h000) begin
          n.tx_timer = s.tx_timer - 11'h001;
        end else begin
          n.tx_phase = TX_IDLE;
        end
      end
      default: n.tx_phase = TX_IDLE;
    endcase

    // APB slave: two wait cycles, then a one-cycle pready
    n.rsp.pready = 1'b0;
    case (s.bus_phase)
      BUS_IDLE: begin
        if (apb_in.psel && apb_in.penable) begin
          n.bus_phase = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        n.bus_phase   = BUS_DONE;
        n.rsp.pready  = 1'b1;
        n.rsp.pslverr = 1'b0;
        n.rsp.prdata  = 32'h0000_0000;
        case (apb_in.paddr)
          `DATA_ADDR: begin
            if (apb_in.pwrite) begin
              if (s.tx_count == `FIFO_DEPTH) begin
                ev_set[`EV_TX_OVF] = 1'b1;
              end else begin
                tx_we       = 1'b1;
                n.tx_wr_ptr = s.tx_wr_ptr + 8'h01;
              end
            end else begin
              // Character bits pass through even when empty
              n.rsp.prdata[`PARITY_ERR_BIT] = rx_rdata[8];
              n.rsp.prdata[`CHAR_MSB:0]     = rx_rdata[`CHAR_MSB:0];
              if (s.rx_count != 9'h000) begin
                rx_pop      = 1'b1;
                n.rx_rd_ptr = s.rx_rd_ptr + 8'h01;
                n.rsp.prdata[`RX_VALID_BIT] = 1'b1;
                n.rsp.prdata[`COUNT_MSB:`COUNT_LSB] =
                  sat8(s.rx_count - 9'h001);
              end
            end
          end
          `CTRL_ADDR: begin
            if (apb_in.pwrite) begin
              n.rx_irq_enable = apb_in.pwdata[`RX_IE_BIT];
              n.tx_irq_enable = apb_in.pwdata[`TX_IE_BIT];
            end
            n.rsp.prdata[`COUNT_MSB:`COUNT_LSB] = sat8(tx_free);
            n.rsp.prdata[`TX_PEND_BIT] = tx_pend;
            n.rsp.prdata[`RX_PEND_BIT] = rx_pend;
            n.rsp.prdata[`TX_IE_BIT]   = s.tx_irq_enable;
            n.rsp.prdata[`RX_IE_BIT]   = s.rx_irq_enable;
          end
          `EV_STATUS_ADDR: begin
            if (apb_in.pwrite) begin
              ev_clr = apb_in.pwdata[2:0];
            end
            n.rsp.prdata[2:0] = s.ev_status;
          end
          `EV_MASK_ADDR: begin
            if (apb_in.pwrite) begin
              n.ev_mask = apb_in.pwdata[2:0];
            end
            n.rsp.prdata[2:0] = s.ev_mask;
          end
          default: n.rsp.pslverr = 1'b1;
        endcase
      end
      BUS_DONE: n.bus_phase = BUS_IDLE;
      default:  n.bus_phase = BUS_IDLE;
    endcase

    // Queue occupancy; a write never touches the receive side
    if (rx_we && !rx_pop) begin
      n.rx_count = s.rx_count + 9'h001;
    end else if (!rx_we && rx_pop) begin
      n.rx_count = s.rx_count - 9'h001;
    end
    if (tx_we && !tx_pop) begin
      n.tx_count = s.tx_count + 9'h001;
    end else if (!tx_we && tx_pop) begin
      n.tx_count = s.tx_count - 9'h001;
    end

    // A new event beats a simultaneous clear
    n.ev_status = (s.ev_status & ~ev_clr) | ev_set;
    // Pending flags drop on their own once the queues move
    n.irq = (s.rx_irq_enable && rx_pend) || (s.tx_irq_enable && tx_pend) ||
            |(s.ev_status & s.ev_mask);
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s               <= '0;
      s.rx_meta       <= 1'b1;
      s.rx_sync       <= 1'b1;
      s.tx_line       <= 1'b1;
      s.rx_irq_enable <= `IE_RESET;
      s.tx_irq_enable <= `IE_RESET;
      s.ev_status     <= `EV_RESET;
      s.ev_mask       <= `EV_RESET;
    end else begin
      s <= n;
    end
  end

  assign apb_out = s.rsp;
  assign ir_tx   = s.tx_line;
  assign irq     = s.irq;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  chk_rx_full_drop: assert property (
    @(posedge clk) disable iff (rst)
    (s.rx_phase == RX_STOP && s.rx_timer == 11'h000 && s.rx_count == `FIFO_DEPTH)
    |=> $stable(s.rx_wr_ptr) && s.ev_status[`EV_RX_OVF])
    else $error("receive store overwritten while full");

  chk_rx_push_count: assert property (
    @(posedge clk) disable iff (rst)
    (rx_we && !rx_pop) |=> s.rx_count == $past(s.rx_count) + 9'h001)
    else $error("receive count missed a push");

  chk_pop_shows_dec: assert property (
    @(posedge clk) disable iff (rst)
    rx_pop |=> s.rsp.pready &&
      s.rsp.prdata[`COUNT_MSB:`COUNT_LSB] == sat8($past(s.rx_count) - 9'h001) &&
      s.rsp.prdata[`RX_VALID_BIT] ##1 !s.rsp.pready)
    else $error("pop answer wrong");

  chk_valid_empty: assert property (
    @(posedge clk) disable iff (rst)
    (rd_data && s.rx_count == 9'h000) |=> !s.rsp.prdata[`RX_VALID_BIT] && s.rsp.pready)
    else $error("valid bit set on empty read");

  chk_write_keeps_rx: assert property (
    @(posedge clk) disable iff (rst)
    (wr_data && !rx_we) |=> s.rx_count == $past(s.rx_count) && $stable(s.rx_rd_ptr))
    else $error("data write disturbed receive side");

  chk_tx_full_drop: assert property (
    @(posedge clk) disable iff (rst)
    (wr_data && s.tx_count == `FIFO_DEPTH && !tx_pop)
    |=> s.tx_count == `FIFO_DEPTH && $stable(s.tx_wr_ptr))
    else $error("write accepted into full transmit store");

  chk_rx_irq_level: assert property (
    @(posedge clk) disable iff (rst)
    (s.rx_irq_enable && s.rx_count > `IRQ_THRESHOLD) |=> irq)
    else $error("receive interrupt missing");

  chk_irq_gated: assert property (
    @(posedge clk) disable iff (rst)
    (!s.rx_irq_enable && !s.tx_irq_enable && (s.ev_status & s.ev_mask) == 3'h0) |=> !irq)
    else $error("interrupt raised while gated");

  chk_tx_start_low: assert property (
    @(posedge clk) disable iff (rst)
    (s.tx_phase == TX_IDLE && s.tx_count != 9'h000)
    |=> !ir_tx && s.tx_phase == TX_START ##1 !ir_tx)
    else $error("start bit not driven low");

  chk_tx_stop_high: assert property (
    @(posedge clk) disable iff (rst)
    (s.tx_phase == TX_STOP) |-> ir_tx)
    else $error("stop bit not high");

endmodule

//--- rtl/ir_uart_defines.svh
// Register map, field positions, reset values and timing counts of the infrared serial port
`ifndef IR_UART_DEFINES_SVH
`define IR_UART_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define DATA_ADDR       32'hFF201020
`define CTRL_ADDR       32'hFF201024
`define EV_STATUS_ADDR  32'hFF201028
`define EV_MASK_ADDR    32'hFF20102C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define COUNT_MSB       23
`define COUNT_LSB       16
`define RX_VALID_BIT    15
`define PARITY_ERR_BIT  9
`define CHAR_MSB        7
`define RX_IE_BIT       0
`define TX_IE_BIT       1
`define RX_PEND_BIT     8
`define TX_PEND_BIT     9
`define EV_RX_OVF       0
`define EV_TX_OVF       1
`define EV_FRAME        2

// ----------------------------------------------------------------------------
// Sizes, reset values and thresholds
// ----------------------------------------------------------------------------
`define FIFO_DEPTH      9'h100
`define IRQ_THRESHOLD   9'h01F
`define IE_RESET        1'h0
`define EV_RESET        3'h0

// ----------------------------------------------------------------------------
// Line timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_HZ     125000000
`define BAUD_RATE       115200
`define BIT_CYCLES      (`CLK_FREQ_HZ / `BAUD_RATE)
`define HALF_BIT_CYCLES (`BIT_CYCLES / 2)

`endif

//--- rtl/ir_uart_pkg.sv
// Types shared by the infrared serial port design
package ir_uart_pkg;

  typedef logic [10:0] bit_timer_t;
  typedef logic [7:0]  fifo_ptr_t;
  typedef logic [8:0]  fifo_count_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_phase_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_phase_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_DONE = 2'b10
  } bus_phase_t;

  typedef struct packed {
    logic        rx_meta;
    logic        rx_sync;
    rx_phase_t   rx_phase;
    bit_timer_t  rx_timer;
    logic [2:0]  rx_bits;
    logic [7:0]  rx_shift;
    fifo_ptr_t   rx_wr_ptr;
    fifo_ptr_t   rx_rd_ptr;
    fifo_count_t rx_count;
    tx_phase_t   tx_phase;
    bit_timer_t  tx_timer;
    logic [2:0]  tx_bits;
    logic [7:0]  tx_shift;
    fifo_ptr_t   tx_wr_ptr;
    fifo_ptr_t   tx_rd_ptr;
    fifo_count_t tx_count;
    logic        tx_line;
    bus_phase_t  bus_phase;
    apb_rsp_t    rsp;
    logic        rx_irq_enable;
    logic        tx_irq_enable;
    logic [2:0]  ev_status;
    logic [2:0]  ev_mask;
    logic        irq;
  } uart_state_t;

endpackage

//--- rtl/char_ram.sv
// Simple dual-port character store with registered, write-first read data
`timescale 1ns/100ps
module char_ram #(
  parameter int WIDTH = 9,
  parameter int AW    = 8
) (
  input  wire logic             clk,    // Core clock
  input  wire logic             we,     // Write strobe
  input  wire logic [AW-1:0]    waddr,  // Write address
  input  wire logic [WIDTH-1:0] wdata,  // Write data
  input  wire logic [AW-1:0]    raddr,  // Read address
  output logic      [WIDTH-1:0] rdata   // Registered read data
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Write-first so a character pushed into an empty queue is seen at once
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

//--- testbench/ir_transceiver_model.sv
// Behavioural model of the infrared transceiver facing the serial port
`timescale 1ns/100ps
module ir_transceiver_model #(
  parameter int BIT_CYC = 1085
) (
  input  wire logic clk,     // Core clock
  input  wire logic tx_line, // Line driven by the port
  output logic      rx_line  // Line driven toward the port
);
  logic [7:0] got_q[$];
  int         n_bad;

  // --------------------------------------------------------------------------
  // Listener on the port output, sampling mid-bit
  // --------------------------------------------------------------------------
  initial begin : listen
    logic [7:0] b;
    n_bad = 0;
    forever begin
      @(negedge tx_line);
      repeat (BIT_CYC / 2) @(posedge clk);
      if (tx_line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge clk);
          b[i] = tx_line;
        end
        repeat (BIT_CYC) @(posedge clk);
        if (tx_line === 1'b1) got_q.push_back(b);
        else n_bad++;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sender; the line idles high between frames
  // --------------------------------------------------------------------------
  initial rx_line = 1'b1;

  // A low stop is only sent when a test asks for a framing fault
  task automatic send(input logic [7:0] c, input logic stop);
    @(posedge clk) rx_line <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      rx_line <= c[i];
    end
    repeat (BIT_CYC) @(posedge clk);
    rx_line <= stop;
    repeat (BIT_CYC) @(posedge clk);
    rx_line <= 1'b1;
  endtask
endmodule

//--- testbench/test_infrared_uart_fifo_port.sv
// Self-checking bench for the infrared serial port
`timescale 1ns/100ps
`include "ir_uart_defines.svh"
module test_infrared_uart_fifo_port;
  import ir_uart_pkg::*;

  typedef struct packed {
    logic [31:0] addr;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] mask;
    logic [31:0] exp;
    logic        err;
  } row_t;

  logic        clk;
  logic        rst;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic        ir_rx;
  logic        ir_tx;
  logic        irq;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [31:0] q;
  logic        e;
  row_t        rows[8];
  logic [7:0]  cs[3] = '{8'h5A, 8'h81, 8'hC3};

  infrared_uart_fifo_port uut (
    .clk     (clk),
    .rst     (rst),
    .apb_in  (req),
    .apb_out (rsp),
    .ir_rx   (ir_rx),
    .ir_tx   (ir_tx),
    .irq     (irq)
  );

  ir_transceiver_model partner (
    .clk     (clk),
    .tx_line (ir_tx),
    .rx_line (ir_rx)
  );

  // --------------------------------------------------------------------------
  // Clock, timeout and reporting
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Serial traffic dominates the run, about 67k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      fail("timeout");
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task fail(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x, input logic [31:0] m);
    checks_done++;
    if ((g & m) !== (x & m)) fail($sformatf("got %h expected %h", g, x));
  endtask

  // Interrupt output lags register changes by one cycle
  task irq_is(input logic x);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, {31'h0, x}, 32'h1);
  endtask

  // --------------------------------------------------------------------------
  // APB master: holds the request until pready is sampled high
  // --------------------------------------------------------------------------
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    req.paddr   <= a;
    req.pwrite  <= w;
    req.pwdata  <= d;
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    @(posedge clk);
    req.penable <= 1'b1;
    // No fixed wait assumed; only the global timeout ends a hang
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rows = '{
      '{`DATA_ADDR, 1'b0, 32'h0, 32'h00FF8000, 32'h0, 1'b0},
      '{`CTRL_ADDR, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h00FF0200, 1'b0},
      '{`EV_STATUS_ADDR, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0},
      '{`EV_MASK_ADDR, 1'b1, 32'h5, 32'h0, 32'h0, 1'b0},
      '{`EV_MASK_ADDR, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h5, 1'b0},
      '{`CTRL_ADDR, 1'b1, 32'h3, 32'h0, 32'h0, 1'b0},
      '{`CTRL_ADDR, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h00FF0203, 1'b0},
      '{32'hFF201030, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1}
    };
    foreach (rows[i]) begin
      apb(rows[i].addr, rows[i].wr, rows[i].wdata);
      chk(q, rows[i].exp, rows[i].mask);
      chk({31'h0, e}, {31'h0, rows[i].err}, 32'h1);
    end
    irq_is(1'b1);
    apb(`CTRL_ADDR, 1'b1, 32'h0);
    irq_is(1'b0);

    // Two back-to-back characters out; upper write bits must be ignored
    apb(`DATA_ADDR, 1'b1, 32'hA5);
    apb(`DATA_ADDR, 1'b1, 32'h13C);
    apb(`DATA_ADDR, 1'b0, 32'h0);
    chk(q, 32'h0, 32'h00FF8000);
    for (int i = 0; i < 30000 && partner.got_q.size() < 2; i++) @(posedge clk);
    chk({24'h0, partner.got_q[0]}, 32'hA5, 32'hFF);
    chk({24'h0, partner.got_q[1]}, 32'h3C, 32'hFF);
    chk(32'(partner.n_bad), 32'h0, 32'hFFFFFFFF);

    // Three characters in, popped in order with a falling count
    foreach (cs[i]) partner.send(cs[i], 1'b1);
    foreach (cs[i]) begin
      apb(`DATA_ADDR, 1'b0, 32'h0);
      chk(q, {8'h0, 8'(2 - i), 1'b1, 7'h0, cs[i]}, 32'h00FF82FF);
    end
    apb(`DATA_ADDR, 1'b0, 32'h0);
    chk(q, 32'h0, 32'h00FF8000);

    // Framing fault: flagged, stored, raises a masked event
    apb(`EV_MASK_ADDR, 1'b1, 32'h4);
    partner.send(8'h96, 1'b0);
    apb(`EV_STATUS_ADDR, 1'b0, 32'h0);
    chk(q, 32'h4, 32'h7);
    irq_is(1'b1);
    apb(`DATA_ADDR, 1'b0, 32'h0);
    chk(q, 32'h00008296, 32'h00FF82FF);
    apb(`EV_STATUS_ADDR, 1'b1, 32'h4);
    irq_is(1'b0);

    // Overfill the transmit queue with its interrupt enabled
    apb(`CTRL_ADDR, 1'b1, 32'h2);
    repeat (258) apb(`DATA_ADDR, 1'b1, 32'h55);
    apb(`CTRL_ADDR, 1'b0, 32'h0);
    chk(q, 32'h00000002, 32'h00FF0203);
    apb(`EV_STATUS_ADDR, 1'b0, 32'h0);
    chk(q, 32'h2, 32'h2);
    irq_is(1'b0);

    // Mid-run reset: queues empty, enables and events cleared
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(`CTRL_ADDR, 1'b0, 32'h0);
    chk(q, 32'h00FF0200, 32'hFFFFFFFF);
    apb(`EV_STATUS_ADDR, 1'b0, 32'h0);
    chk(q, 32'h0, 32'hFFFFFFFF);
    irq_is(1'b0);
    report_and_stop();
  end
endmodule
